/* File: hw/serial_port_ctrl.sv */
// Control, status and baud rate generator of the serial port.
// Assumes shift datapaths outside report events on stat_i for one cycle each
// and follow ctrl_o; software reaches registers over AXI4-Lite.
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
module serial_port_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire serial_port_pkg::stat_t stat_i,
  output serial_port_pkg::ctrl_t ctrl_o,
  output logic baud_tick_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by the read and write paths
  function automatic serial_port_pkg::reg_sel_t reg_sel(input logic [7:0] addr);
    case (addr)
      serial_port_pkg::OFF_TX_CTRL: reg_sel = serial_port_pkg::SEL_TX;
      serial_port_pkg::OFF_RX_CTRL: reg_sel = serial_port_pkg::SEL_RX;
      serial_port_pkg::OFF_BAUD_CTRL: reg_sel = serial_port_pkg::SEL_BAUD;
      serial_port_pkg::OFF_DIV_LOW: reg_sel = serial_port_pkg::SEL_DLO;
      serial_port_pkg::OFF_DIV_HIGH: reg_sel = serial_port_pkg::SEL_DHI;
      serial_port_pkg::OFF_RX_DATA: reg_sel = serial_port_pkg::SEL_DATA;
      default: reg_sel = serial_port_pkg::SEL_NONE;
    endcase
  endfunction : reg_sel

  // Bus state
  logic aw_held_r, w_held_r; // Address / data captured, waiting for partner
  logic [7:0] awaddr_r;
  logic [7:0] wbyte_r;       // Only the low lane carries register bits
  logic wlane_r;             // Low byte lane strobe
  logic aw_hs, w_hs, ar_hs, do_write, wr_en, rd_pop;
  logic aw_held_nxt, w_held_nxt, bvalid_nxt, rvalid_nxt;
  serial_port_pkg::reg_sel_t wr_sel, rd_sel;
  logic [31:0] rd_val;

  // Software visible registers
  logic [7:0] txc_r, rxc_r, bdc_r, div_lo_r, div_hi_r;
  logic shift_empty_r, framing_error_r, overrun_error_r, ninth_r, abd_ovf_r, receive_idle_flag_r;
  logic [7:0] rx_data_r;     // Held character
  logic rx_full_r;           // Receive buffer occupied
  logic rx_flag_r;           // Receive flag: character or wake event

  // Decoded mode
  logic port_en, sync_m, async_m, rx_en_eff, accept;

  // Baud generator
  logic [5:0] pre_r, pre_term;
  logic [15:0] tmr_r, div_n;
  logic pre_wrap, tmr_wrap;

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes: address and data are taken in either order, write runs
  // one edge after both are held, so the response always follows both.
  assign aw_hs = awvalid && awready;
  assign w_hs = wvalid && wready;
  assign ar_hs = arvalid && arready;
  assign do_write = aw_held_r && w_held_r;
  assign wr_sel = reg_sel(awaddr_r);
  assign wr_en = do_write && wlane_r;
  assign rd_sel = reg_sel(araddr);
  assign rd_pop = ar_hs && (rd_sel == serial_port_pkg::SEL_DATA);
  assign aw_held_nxt = aw_hs || (aw_held_r && !do_write);
  assign w_held_nxt = w_hs || (w_held_r && !do_write);
  assign bvalid_nxt = do_write || (bvalid && !bready);
  assign rvalid_nxt = ar_hs || (rvalid && !rready);

  // Write channel state; ready drops once a beat is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= serial_port_pkg::RESP_OKAY;
      awaddr_r <= 8'h00;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      bvalid <= bvalid_nxt;
      // Ready stays low while a beat waits or a response is pending
      awready <= !aw_held_nxt && !bvalid_nxt && !do_write;
      wready <= !w_held_nxt && !bvalid_nxt && !do_write;
      if (aw_hs) begin
        awaddr_r <= awaddr;
      end
      if (w_hs) begin
        wbyte_r <= wdata[7:0];
        wlane_r <= wstrb[0];
      end
      // Unmapped addresses answer with an error and change nothing
      if (do_write) begin
        bresp <= (wr_sel == serial_port_pkg::SEL_NONE) ? serial_port_pkg::RESP_SLVERR
                                                        : serial_port_pkg::RESP_OKAY;
      end
    end
  end

  // Read value mux
  always_comb begin
    rd_val = 32'h0000_0000;
    case (rd_sel)
      serial_port_pkg::SEL_TX: begin
        rd_val[7:0] = txc_r;
        rd_val[serial_port_pkg::TX_EMPTY_BIT] = shift_empty_r;
      end
      serial_port_pkg::SEL_RX: begin
        rd_val[7:0] = {rxc_r[7:3], framing_error_r, overrun_error_r, ninth_r};
      end
      serial_port_pkg::SEL_BAUD: begin
        rd_val[7:0] = {abd_ovf_r, receive_idle_flag_r, bdc_r[5:0]};
      end
      serial_port_pkg::SEL_DLO: rd_val[7:0] = div_lo_r;
      serial_port_pkg::SEL_DHI: rd_val[7:0] = div_hi_r;
      serial_port_pkg::SEL_DATA: begin
        rd_val[7:0] = rx_data_r;
        rd_val[serial_port_pkg::RXD_FLAG_BIT] = rx_flag_r;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Read channel: answer on the same edge that takes the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= serial_port_pkg::RESP_OKAY;
    end else begin
      rvalid <= rvalid_nxt;
      arready <= !rvalid_nxt;
      if (ar_hs) begin
        rdata <= rd_val;
        rresp <= (rd_sel == serial_port_pkg::SEL_NONE) ? serial_port_pkg::RESP_SLVERR
                                                        : serial_port_pkg::RESP_OKAY;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  assign port_en = rxc_r[serial_port_pkg::RX_PORTEN_BIT];
  assign sync_m = txc_r[serial_port_pkg::TX_SYNC_BIT];
  assign async_m = !sync_m;
  // Continuous receive in either mode; single receive only as sync master
  assign rx_en_eff = rxc_r[serial_port_pkg::RX_CONT_BIT] ||
                     (sync_m && txc_r[serial_port_pkg::TX_CLKSRC_BIT] &&
                      rxc_r[serial_port_pkg::RX_SINGLE_BIT]);
  // Address filter drops characters without the ninth bit in async nine-bit
  assign accept = port_en && stat_i.rx_done && rx_en_eff && !overrun_error_r &&
                  !(async_m && rxc_r[serial_port_pkg::RX_NINE_BIT] &&
                    rxc_r[serial_port_pkg::RX_ADDR_BIT] && !stat_i.rx_char[8]);

  // Transmit control; software write beats the hardware break clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txc_r <= serial_port_pkg::CTRL_RST;
    end else begin
      if (stat_i.break_done) begin
        txc_r[serial_port_pkg::TX_BREAK_BIT] <= 1'b0;
      end
      if (wr_en && wr_sel == serial_port_pkg::SEL_TX) begin
        txc_r <= wbyte_r & serial_port_pkg::TX_WMASK;
      end
    end
  end

  // Receive control; single receive ends itself after one character
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxc_r <= serial_port_pkg::CTRL_RST;
    end else begin
      if (stat_i.sync_rx_done && sync_m) begin
        rxc_r[serial_port_pkg::RX_SINGLE_BIT] <= 1'b0;
      end
      if (wr_en && wr_sel == serial_port_pkg::SEL_RX) begin
        rxc_r <= wbyte_r & serial_port_pkg::RX_WMASK;
      end
    end
  end

  // Baud control; wake and auto-baud bits are cleared by their events
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bdc_r <= serial_port_pkg::CTRL_RST;
    end else begin
      if (async_m && stat_i.wake_edge) begin
        bdc_r[serial_port_pkg::BD_WAKE_BIT] <= 1'b0;
      end
      if (async_m && stat_i.abd_done) begin
        bdc_r[serial_port_pkg::BD_AUTO_BIT] <= 1'b0;
      end
      if (wr_en && wr_sel == serial_port_pkg::SEL_BAUD) begin
        bdc_r <= wbyte_r & serial_port_pkg::BD_WMASK;
      end
    end
  end

  // Divisor pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_lo_r <= serial_port_pkg::DIV_RST;
      div_hi_r <= serial_port_pkg::DIV_RST;
    end else if (wr_en && wr_sel == serial_port_pkg::SEL_DLO) begin
      div_lo_r <= wbyte_r;
    end else if (wr_en && wr_sel == serial_port_pkg::SEL_DHI) begin
      div_hi_r <= wbyte_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; a disabled port holds all of them at their reset state
  always_ff @(posedge aclk) begin
    if (!aresetn || !port_en) begin
      shift_empty_r <= 1'b1;
      receive_idle_flag_r <= 1'b1;
      abd_ovf_r <= 1'b0;
    end else begin
      shift_empty_r <= !stat_i.tsr_full;
      // Idle means nothing between start bit and character end
      if (sync_m || stat_i.rx_done) begin
        receive_idle_flag_r <= 1'b1;
      end else if (stat_i.rx_start) begin
        receive_idle_flag_r <= 1'b0;
      end
      // Overflow only counts in async mode; sticky until port disabled
      if (async_m && stat_i.abd_ovf) begin
        abd_ovf_r <= 1'b1;
      end
    end
  end

  // Overrun: clearing continuous receive wins over a new overrun, since
  // the clear, like disabling the port, is how software recovers the receiver
  always_ff @(posedge aclk) begin
    if (!aresetn || !port_en || !rxc_r[serial_port_pkg::RX_CONT_BIT]) begin
      overrun_error_r <= 1'b0;
    end else if (accept && rx_full_r && !rd_pop) begin
      overrun_error_r <= 1'b1;
    end
  end

  // Receive buffer: one held character with its framing and ninth bit
  always_ff @(posedge aclk) begin
    if (!aresetn || !port_en) begin
      rx_full_r <= 1'b0;
      rx_data_r <= 8'h00;
      framing_error_r <= 1'b0;
      ninth_r <= 1'b0;
    end else if (accept && (!rx_full_r || rd_pop)) begin
      rx_full_r <= 1'b1;
      rx_data_r <= stat_i.rx_char[7:0];
      framing_error_r <= stat_i.rx_framing_error;
      ninth_r <= stat_i.rx_char[8];
    end else if (rd_pop) begin
      rx_full_r <= 1'b0;
    end
  end

  // Receive flag: a loaded character or a wake edge, cleared by the pop;
  // a new event in the pop cycle keeps the flag set
  always_ff @(posedge aclk) begin
    if (!aresetn || !port_en) begin
      rx_flag_r <= 1'b0;
    end else if ((accept && (!rx_full_r || rd_pop)) ||
                 (async_m && bdc_r[serial_port_pkg::BD_WAKE_BIT] && stat_i.wake_edge)) begin
      rx_flag_r <= 1'b1;
    end else if (rd_pop) begin
      rx_flag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud generator: prescaler times divisor counter gives the bit period
  assign div_n = bdc_r[serial_port_pkg::BD_SIXTEEN_BIT] ? {div_hi_r, div_lo_r}
                                                        : {8'h00, div_lo_r};
  // Async high speed ignored in sync; both speed bits give the fast rate
  always_comb begin
    if (sync_m) begin
      pre_term = serial_port_pkg::PRE_FAST;
    end else if (txc_r[serial_port_pkg::TX_HSPEED_BIT] &&
                 bdc_r[serial_port_pkg::BD_SIXTEEN_BIT]) begin
      pre_term = serial_port_pkg::PRE_FAST;
    end else if (txc_r[serial_port_pkg::TX_HSPEED_BIT] ||
                 bdc_r[serial_port_pkg::BD_SIXTEEN_BIT]) begin
      pre_term = serial_port_pkg::PRE_ASYNC_MID;
    end else begin
      pre_term = serial_port_pkg::PRE_ASYNC_LOW;
    end
  end
  // Compare with >= so a width change never strands the counter above n
  assign pre_wrap = (pre_r >= pre_term);
  assign tmr_wrap = (tmr_r >= div_n);

  // Free-running timer; a divisor write restarts it so the new rate
  // applies at once rather than after the old period runs out
  always_ff @(posedge aclk) begin
    if (!aresetn || !port_en ||
        (wr_en && (wr_sel == serial_port_pkg::SEL_DLO ||
                   wr_sel == serial_port_pkg::SEL_DHI))) begin
      pre_r <= 6'h00;
      tmr_r <= 16'h0000;
      baud_tick_o <= 1'b0;
    end else begin
      pre_r <= pre_wrap ? 6'h00 : pre_r + 6'h01;
      if (pre_wrap) begin
        tmr_r <= tmr_wrap ? 16'h0000 : tmr_r + 16'h0001;
      end
      baud_tick_o <= pre_wrap && tmr_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control to the datapaths, registered; mode-dependent bits are masked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_o <= '0;
    end else begin
      ctrl_o.enable <= port_en;
      ctrl_o.sync_mode <= sync_m;
      ctrl_o.master <= sync_m && txc_r[serial_port_pkg::TX_CLKSRC_BIT];
      ctrl_o.tx_nine <= txc_r[serial_port_pkg::TX_NINE_BIT];
      ctrl_o.tx_en <= port_en && txc_r[serial_port_pkg::TX_EN_BIT] &&
                      !(sync_m && rx_en_eff);
      ctrl_o.tx_break <= async_m && txc_r[serial_port_pkg::TX_BREAK_BIT];
      ctrl_o.tx_ninth <= txc_r[serial_port_pkg::TX_NINTH_BIT];
      ctrl_o.rx_nine <= rxc_r[serial_port_pkg::RX_NINE_BIT];
      ctrl_o.rx_en <= port_en && rx_en_eff && !overrun_error_r;
      ctrl_o.addr_detect <= async_m && rxc_r[serial_port_pkg::RX_NINE_BIT] &&
                            rxc_r[serial_port_pkg::RX_ADDR_BIT];
      ctrl_o.polarity <= bdc_r[serial_port_pkg::BD_POL_BIT];
      ctrl_o.wake <= async_m && bdc_r[serial_port_pkg::BD_WAKE_BIT];
      ctrl_o.autobaud <= async_m && bdc_r[serial_port_pkg::BD_AUTO_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  div_restart_a: assert property (
    wr_en && wr_sel == serial_port_pkg::SEL_DLO |=> pre_r == 6'h00 && tmr_r == 16'h0000)
    else $error("divisor write did not restart baud timer");
  tick_spacing_a: assert property (
    baud_tick_o |=> !baud_tick_o [*3])
    else $error("baud ticks closer than four cycles");
  break_clear_a: assert property (
    stat_i.break_done && !wr_en |=> !txc_r[serial_port_pkg::TX_BREAK_BIT])
    else $error("break request not cleared after break");
  single_clear_a: assert property (
    stat_i.sync_rx_done && sync_m && !wr_en |=> !rxc_r[serial_port_pkg::RX_SINGLE_BIT])
    else $error("single receive not cleared");
  overrun_clear_a: assert property (
    !rxc_r[serial_port_pkg::RX_CONT_BIT] |=> !overrun_error_r)
    else $error("overrun survives continuous receive clear");
  tx_yield_a: assert property (
    sync_m && rxc_r[serial_port_pkg::RX_CONT_BIT] |=> !ctrl_o.tx_en)
    else $error("transmit enabled while sync receive active");
  idle_drop_a: assert property (
    port_en && async_m && stat_i.rx_start && !stat_i.rx_done && !wr_en |=> !receive_idle_flag_r)
    else $error("idle flag high after start bit");
  addr_filter_a: assert property (
    ctrl_o.addr_detect && async_m && rxc_r[serial_port_pkg::RX_ADDR_BIT] &&
    rxc_r[serial_port_pkg::RX_NINE_BIT] && stat_i.rx_done && !stat_i.rx_char[8]
    |=> $stable(rx_data_r))
    else $error("address filter loaded a data character");
  empty_track_a: assert property (
    port_en && !wr_en |=> shift_empty_r == !$past(stat_i.tsr_full))
    else $error("shift-empty status does not follow shift register");
  write_answer_a: assert property (
    do_write |=> bvalid)
    else $error("write response missing");

  tick_seen_c: cover property (baud_tick_o ##[4:300] baud_tick_o);
  char_pop_c: cover property (accept ##[1:20] rd_pop);
  overrun_c: cover property (!overrun_error_r ##1 overrun_error_r);

endmodule : serial_port_ctrl

/* File: hw/serial_port_pkg.sv */
// Shared constants and carriers for the serial port control and baud block.
// Assumes an AXI4-Lite master with 32-bit data and byte addresses on 8 bits.
package serial_port_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFF_TX_CTRL = 8'h00;
  localparam logic [7:0] OFF_RX_CTRL = 8'h04;
  localparam logic [7:0] OFF_BAUD_CTRL = 8'h08;
  localparam logic [7:0] OFF_DIV_LOW = 8'h0c;
  localparam logic [7:0] OFF_DIV_HIGH = 8'h10;
  localparam logic [7:0] OFF_RX_DATA = 8'h14;

  // Register select codes from the address decoder
  typedef enum logic [2:0] {
    SEL_TX, SEL_RX, SEL_BAUD, SEL_DLO, SEL_DHI, SEL_DATA, SEL_NONE
  } reg_sel_t;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit status/control field positions
  localparam int TX_CLKSRC_BIT = 7;
  localparam int TX_NINE_BIT = 6;
  localparam int TX_EN_BIT = 5;
  localparam int TX_SYNC_BIT = 4;
  localparam int TX_BREAK_BIT = 3;
  localparam int TX_HSPEED_BIT = 2;
  localparam int TX_EMPTY_BIT = 1;
  localparam int TX_NINTH_BIT = 0;
  // Receive status/control field positions
  localparam int RX_PORTEN_BIT = 7;
  localparam int RX_NINE_BIT = 6;
  localparam int RX_SINGLE_BIT = 5;
  localparam int RX_CONT_BIT = 4;
  localparam int RX_ADDR_BIT = 3;
  // Baud control field positions
  localparam int BD_SIXTEEN_BIT = 3;
  localparam int BD_POL_BIT = 4;
  localparam int BD_WAKE_BIT = 1;
  localparam int BD_AUTO_BIT = 0;
  // Receive data register: flag above the data byte
  localparam int RXD_FLAG_BIT = 8;

  // Writable bit masks and reset values
  localparam logic [7:0] TX_WMASK = 8'hfd;
  localparam logic [7:0] RX_WMASK = 8'hf8;
  localparam logic [7:0] BD_WMASK = 8'h1b;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;

  // Prescaler terminal counts: multiplier minus one
  localparam logic [5:0] PRE_ASYNC_LOW = 6'h3f;
  localparam logic [5:0] PRE_ASYNC_MID = 6'h0f;
  localparam logic [5:0] PRE_FAST = 6'h03;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Control handed to the shift datapaths
  typedef struct packed {
    logic enable;       // Port on, pins owned by the port
    logic sync_mode;    // Synchronous operation
    logic master;       // Sync clock generated here
    logic tx_nine;      // Nine-bit transmit
    logic tx_en;        // Transmitter enabled after precedence
    logic tx_break;     // Next transmission is a break
    logic tx_ninth;     // Ninth transmit bit
    logic rx_nine;      // Nine-bit receive
    logic rx_en;        // Receiver enabled
    logic addr_detect;  // Address filter active
    logic polarity;     // Invert data / clock edge select
    logic wake;         // Waiting for a wake edge
    logic autobaud;     // Auto-baud measurement requested
  } ctrl_t;

  // Events and state from the shift datapaths
  typedef struct packed {
    logic tsr_full;        // Transmit shift register holds data
    logic break_done;      // Break character finished
    logic rx_start;        // Start bit detected
    logic rx_done;         // Character complete, fields below valid
    logic rx_framing_error;         // Its stop bit was bad
    logic [8:0] rx_char;   // Character, bit 8 the ninth bit
    logic sync_rx_done;    // Single synchronous reception ended
    logic wake_edge;       // Falling edge seen on receive input
    logic abd_done;        // Auto-baud measurement finished
    logic abd_ovf;         // Auto-baud timer overflowed
  } stat_t;

endpackage : serial_port_pkg

/* File: verification/serial_datapath_model.sv */
// Stand-in for the shift datapaths that sit beside the control block.
// Assumes the bench asks for received characters with one-cycle requests.
`timescale 1ns/10ps
module serial_datapath_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire serial_port_pkg::ctrl_t ctrl,
  input wire logic send,
  input wire logic [8:0] chr,
  input wire logic framing_error,
  output serial_port_pkg::stat_t stat
);
  // Events answer one edge after the request; the done pulses are not repeated back to back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat <= '0;
    end else begin
      stat.tsr_full <= ctrl.enable & ctrl.tx_en;
      stat.break_done <= ctrl.enable & ctrl.tx_break & ~stat.break_done;
      stat.wake_edge <= ctrl.enable & ctrl.wake & ~stat.wake_edge;
      stat.abd_done <= ctrl.enable & ctrl.autobaud & ~stat.abd_done;
      // Overflow reported together with each measurement end
      stat.abd_ovf <= ctrl.enable & ctrl.autobaud & ~stat.abd_done;
      // Sync master receptions end every other cycle while enabled
      stat.sync_rx_done <= ctrl.enable & ctrl.master & ctrl.rx_en & ~stat.sync_rx_done;
      // Start bit one edge before the character completes; chr is held meanwhile
      stat.rx_start <= send & ctrl.rx_en;
      // Characters are only delivered while the receiver is on
      stat.rx_done <= stat.rx_start;
      stat.rx_char <= chr;
      stat.rx_framing_error <= framing_error;
    end
  end
endmodule : serial_datapath_model

/* File: verification/serial_port_ctrl_tb.sv */
// Self-checking bench for the serial port control and baud block.
// Assumes the datapath model above on the status side.
`timescale 1ns/10ps
module serial_port_ctrl_tb;
  localparam logic [7:0] TX = serial_port_pkg::OFF_TX_CTRL;
  localparam logic [7:0] RX = serial_port_pkg::OFF_RX_CTRL;
  localparam logic [7:0] BD = serial_port_pkg::OFF_BAUD_CTRL;
  localparam logic [7:0] DL = serial_port_pkg::OFF_DIV_LOW;
  localparam logic [7:0] DH = serial_port_pkg::OFF_DIV_HIGH;
  localparam logic [7:0] RD = serial_port_pkg::OFF_RX_DATA;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, send, framing_error;
  logic awready, wready, bvalid, arready, rvalid, baud_tick_o;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v, w;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [8:0] chr;
  logic [2:0] cfg;
  serial_port_pkg::ctrl_t ctrl_o;
  serial_port_pkg::stat_t stat_i;
  int n_mismatch, checked, seed, c, n;
  serial_port_ctrl serial_port_ctrl_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .stat_i(stat_i), .ctrl_o(ctrl_o), .baud_tick_o(baud_tick_o));
  serial_datapath_model serial_datapath_model_inst (.aclk(aclk), .aresetn(aresetn),
    .ctrl(ctrl_o), .send(send), .chr(chr), .framing_error(framing_error), .stat(stat_i));
  ////////////////////////////////////////////////////////////////////////////
  // 100 ns clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task stop_test;
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  // Bit period in cycles; f is {sync, high speed, sixteen}
  function automatic int period(input logic [2:0] f, input int k);
    if (f[2] || (f[1] && f[0])) return 4 * (k + 1);
    return ((f[1] || f[0]) ? 16 : 64) * (k + 1);
  endfunction : period
  // Write: address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    // Response ready stays high, so back-to-back calls drive it once per step
    resp = bresp;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    resp = rresp;
  endtask : rd
  // One received character from the line side
  task rx(input logic [8:0] c9, input logic fe);
    send <= 1'b1;
    chr <= c9;
    framing_error <= fe;
    @(posedge aclk);
    send <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : rx
  ////////////////////////////////////////////////////////////////////////////
  // Hang guard, far beyond the longest expected run
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    stop_test;
  end
  initial begin
    seed = 94426;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, send, framing_error} = 8'h00;
    {awaddr, araddr, wdata, wstrb, chr} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(TX, w); chk(w, 32'h02);
    rd(RX, w); chk(w, 32'h00);
    rd(BD, w); chk(w, 32'h40);
    // Random readback with the port off
    repeat (4) begin
      v = $random(seed);
      wr(TX, v); rd(TX, w); chk(w, {24'h0, v[7:0] & serial_port_pkg::TX_WMASK | 8'h02});
      wr(BD, v); rd(BD, w); chk(w, {24'h0, v[7:0] & serial_port_pkg::BD_WMASK | 8'h40});
      wr(DH, v); rd(DH, w); chk(w, {24'h0, v[7:0]});
    end
    rd(8'h18, w); chk({30'h0, resp}, 32'h2);
    wr(8'h1c, v); chk({30'h0, resp}, 32'h2);
    // Every rate multiplier, small random divisor
    wr(RX, 32'h80);
    for (int i = 0; i < 5; i++) begin
      cfg = i[2:0];
      n = {$random(seed)} % 4;
      wr(TX, {27'h0, cfg[2], 1'b0, cfg[1], 2'b00});
      wr(BD, {28'h0, cfg[0], 3'h0});
      wr(DH, 32'h0);
      wr(DL, n);
      do @(posedge aclk); while (!baud_tick_o);
      c = 0;
      do begin @(posedge aclk); c++; end while (!baud_tick_o);
      chk(c, period(cfg, n));
    end
    wr(TX, 32'hb0); wr(RX, 32'hb0); repeat (2) @(posedge aclk);
    chk({28'h0, ctrl_o.master, ctrl_o.sync_mode, ctrl_o.tx_en, ctrl_o.enable}, 32'hd);
    rd(RX, w); chk({31'h0, w[5]}, 32'h0);
    // Enable reaches the shift register status three edges after the write lands
    wr(TX, 32'h20); repeat (2) @(posedge aclk); rd(TX, w); chk(w, 32'h20);
    // Nine-bit character with random framing flag
    wr(RX, 32'hd0); v = $random(seed); rx(v[8:0], v[9]);
    rd(RX, w); chk(w, {24'h0, 8'hd0 | {5'h0, v[9], 1'b0, v[8]}});
    rd(RD, w); chk(w, {23'h0, 1'b1, v[7:0]});
    rx(9'h011, 1'b0); rx(9'h022, 1'b0);
    rd(RX, w); chk({31'h0, w[1]}, 32'h1);
    wr(RX, 32'hc0); rd(RX, w); chk({31'h0, w[1]}, 32'h0);
    rd(RD, w);
    wr(RX, 32'hd8); rx(9'h0aa, 1'b0); rd(RD, w); chk({31'h0, w[8]}, 32'h0);
    rx(9'h155, 1'b0); rd(RD, w); chk(w, 32'h155);
    // Async nine-bit with address filter, polarity set: whole control word
    wr(TX, 32'h41); wr(BD, 32'h10); repeat (2) @(posedge aclk);
    chk({19'h0, ctrl_o}, 32'h127c);
    // Self-clearing requests
    wr(TX, 32'h08); wr(BD, 32'h03); repeat (4) @(posedge aclk);
    rd(TX, w); chk({31'h0, w[3]}, 32'h0);
    rd(BD, w); chk({30'h0, w[1:0]}, 32'h0);
    chk({31'h0, w[7]}, 32'h1);
    rd(RD, w); chk({31'h0, w[8]}, 32'h1);
    stop_test;
  end
endmodule : serial_port_ctrl_tb
